// *** include/flash_pin_pkg.sv ***
package flash_pin_pkg;

  // ****************************************
  // Widths and pin positions
  // ****************************************
  localparam int BYTE_W = 8;          // Serial shift unit
  localparam int LANES = 4;           // Data lines 0..3
  localparam int SYNC_W = 6;          // Select, clock and four lanes
  localparam int PIN_CS = 5;          // Select position in pin vector
  localparam int PIN_SCK = 4;         // Clock position in pin vector
  localparam int LANE_WP = 2;         // Data line 2 doubles as protect
  localparam int LANE_HOLD = 3;       // Data line 3 doubles as pause
  localparam int FIFO_DEPTH = 2;      // Receive buffer entries

  // ****************************************
  // Protected status bits
  // ****************************************
  localparam int PROT_W = 6;          // Disable, quad, four protect
  localparam int WDIS_POS = 5;        // Status-write-disable bit
  localparam int QUAD_POS = 4;        // Quad-enable bit
  localparam logic [5:0] PROT_RST = 6'h00;

  // ****************************************
  // Lane steps, drive masks, fill byte
  // ****************************************
  localparam logic [2:0] STEP_1 = 3'h1;
  localparam logic [2:0] STEP_2 = 3'h2;
  localparam logic [2:0] STEP_4 = 3'h4;
  localparam logic [3:0] MASK_1 = 4'h2; // Output pin only
  localparam logic [3:0] MASK_2 = 4'h3; // Lines 0 and 1
  localparam logic [3:0] MASK_4 = 4'hF; // All four lines
  localparam logic [7:0] TX_FILL = 8'hFF; // Sent when no byte waits

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    W_SINGLE = 2'b00,
    W_DUAL = 2'b01,
    W_QUAD = 2'b10
  } width_t;

  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_ACTIVE = 2'b01,
    LS_PAUSED = 2'b10
  } link_t;

endpackage

// *** rtl/serial_flash_pin_interface.sv ***
`timescale 1ns/1ps
// Function
// - Select high: deselected, pins released, standby
// - Select low: selected, leaves standby
// - No instruction before first select falling edge
// - Ignore serial data while select high
// - Single mode samples input on rising clock
// - Single mode drives output on falling clock
// - Dual/quad: lines 0,1 bidirectional by phase
// - Quad uses protect and pause pins as lanes
// - Disable bit and protect low reject writes
// - Disable bit zero allows all status writes
// - Quad enable removes protect pin function
// - Pause suspends without resetting sequence
// - Paused and selected: output pin released
// - Pause high resumes suspended operation
// - Quad enable removes pause pin function
// - Clock modes 0 and 3, same edges
module serial_flash_pin_interface (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Link pins
  input wire logic sel_n_i,
  input wire logic sck_i,
  input wire logic data_line_0_i,
  output logic data_line_0_o,
  output logic data_line_0_oe_o,
  input wire logic data_line_1_i,
  output logic data_line_1_o,
  output logic data_line_1_oe_o,
  input wire logic data_line_2_i,
  output logic data_line_2_o,
  output logic data_line_2_oe_o,
  input wire logic data_line_3_i,
  output logic data_line_3_o,
  output logic data_line_3_oe_o,
  // Transfer phase from command logic
  input wire flash_pin_pkg::width_t width_i,
  input wire logic drive_i,
  // Received bytes
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [flash_pin_pkg::BYTE_W-1:0] rx_data_o,
  // Bytes to send
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [flash_pin_pkg::BYTE_W-1:0] tx_data_i,
  // Protected status bits
  input wire logic sr_wr_i,
  input wire logic [flash_pin_pkg::PROT_W-1:0] sr_wdata_i,
  output logic [flash_pin_pkg::PROT_W-1:0] sr_bits_o,
  // Link status
  output logic standby_o,
  output logic paused_o,
  output logic overrun_o,
  input wire logic overrun_clr_i
);
  import flash_pin_pkg::*;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Bits moved per clock edge
  function automatic logic [2:0] step_of(input width_t w);
    case (w)
      W_DUAL: step_of = STEP_2;
      W_QUAD: step_of = STEP_4;
      default: step_of = STEP_1;
    endcase
  endfunction

  // Lines driven in a sending phase
  function automatic logic [3:0] mask_of(input width_t w);
    case (w)
      W_DUAL: mask_of = MASK_2;
      W_QUAD: mask_of = MASK_4;
      default: mask_of = MASK_1;
    endcase
  endfunction

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic [1:0] rst_q_ff;       // Reset release pair
  logic rst_n;                // Synchronised reset
  logic [SYNC_W-1:0] pins;    // Raw pins
  logic [SYNC_W-1:0] s1_ff;   // First stage, read by s2 only
  logic [SYNC_W-1:0] s2_ff;   // Usable copies
  logic [SYNC_W-1:0] nxt_s1;
  logic [SYNC_W-1:0] nxt_s2;

  // Release is delayed two edges; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q_ff <= 2'h0;
    end else begin
      rst_q_ff <= {rst_q_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_q_ff[1];

  assign pins = {sel_n_i, sck_i, data_line_3_i, data_line_2_i,
                 data_line_1_i, data_line_0_i};

  // Each pin passes two flops before any logic looks at it
  generate
    for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
      always_comb begin
        nxt_s1[g] = pins[g];
        nxt_s2[g] = s1_ff[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

  // ****************************************
  // Link state
  // ****************************************
  logic cs_s;                 // Select, high means deselected
  logic hold_s;               // Pause pin level
  logic wp_s;                 // Protect pin level
  logic quad_en;              // Quad enable
  link_t link_ff;
  link_t nxt_link;
  logic armed_ff;             // Select seen high since reset
  logic nxt_armed;
  logic active;

  assign cs_s = s2_ff[PIN_CS];
  assign hold_s = s2_ff[LANE_HOLD];
  assign wp_s = s2_ff[LANE_WP];
  assign active = (link_ff == LS_ACTIVE);

  // Select, arm and pause sequencing
  always_comb begin
    nxt_armed = armed_ff | cs_s;
    nxt_link = link_ff;
    case (link_ff)
      LS_IDLE: begin
        // Only a high-to-low select after reset opens the link
        if (armed_ff && !cs_s) begin
          nxt_link = LS_ACTIVE;
        end
      end
      LS_ACTIVE: begin
        if (cs_s) begin
          nxt_link = LS_IDLE;
        end else if (!hold_s && !quad_en) begin
          nxt_link = LS_PAUSED;
        end
      end
      LS_PAUSED: begin
        if (cs_s) begin
          nxt_link = LS_IDLE;
        end else if (hold_s || quad_en) begin
          nxt_link = LS_ACTIVE;
        end
      end
      default: nxt_link = LS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_ff <= LS_IDLE;
      armed_ff <= 1'b0;
    end else begin
      link_ff <= nxt_link;
      armed_ff <= nxt_armed;
    end
  end

  assign standby_o = (link_ff == LS_IDLE);
  assign paused_o = (link_ff == LS_PAUSED);

  // ****************************************
  // Serial shifting
  // ****************************************
  // Quad without the enable bit would fight the protect and
  // pause pins, so it falls back to single lane
  width_t eff_w;
  logic [2:0] step;
  logic sck_prev_ff;
  logic rise;
  logic fall;
  logic rx_go;
  logic tx_go;
  logic [2:0] cnt_ff;         // Bits done in current byte
  logic [2:0] nxt_cnt;
  logic [2:0] cnt_sum;
  logic [7:0] rx_sh_ff;
  logic [7:0] nxt_rx_sh;
  logic [7:0] tx_sh_ff;
  logic [7:0] nxt_tx_sh;
  logic [7:0] tx_word;
  logic [3:0] dout_ff;
  logic [3:0] nxt_dout;
  logic [3:0] drv_ff;
  logic [3:0] nxt_drv;
  logic [7:0] lanes;
  logic byte_done;

  assign eff_w = (width_i == W_QUAD && !quad_en) ? W_SINGLE : width_i;
  assign step = step_of(eff_w);
  // Edges of the sampled clock; idle level does not matter
  assign rise = s2_ff[PIN_SCK] & ~sck_prev_ff;
  assign fall = ~s2_ff[PIN_SCK] & sck_prev_ff;
  // Nothing moves unless selected and not paused; the synced select
  // also gates, so an edge in the cycle select rises is dropped
  assign rx_go = active & ~cs_s & rise & ~drive_i;
  assign tx_go = active & ~cs_s & fall & drive_i;
  assign cnt_sum = cnt_ff + step;
  assign byte_done = rx_go && (cnt_sum == 3'h0);
  assign tx_ready_o = tx_go && (cnt_ff == 3'h0) && tx_valid_i;
  assign tx_word = tx_valid_i ? tx_data_i : TX_FILL;

  // Input lanes by width, most significant lane first
  always_comb begin
    lanes = 8'h00;
    case (eff_w)
      W_DUAL: lanes[1:0] = s2_ff[1:0];
      W_QUAD: lanes[3:0] = s2_ff[3:0];
      default: lanes[0] = s2_ff[0];
    endcase
  end

  // Shift, count and drive next values
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_dout = dout_ff;
    nxt_drv = drv_ff;
    if (link_ff == LS_IDLE) begin
      // A new select starts a fresh sequence
      nxt_cnt = 3'h0;
      nxt_drv = 4'h0;
    end else if (rx_go) begin
      nxt_rx_sh = (rx_sh_ff << step) | lanes;
      nxt_cnt = cnt_sum;
      nxt_drv = 4'h0;
    end else if (tx_go) begin
      nxt_cnt = cnt_sum;
      nxt_drv = mask_of(eff_w);
      if (cnt_ff == 3'h0) begin
        nxt_tx_sh = tx_word << step;
        nxt_dout = (eff_w == W_SINGLE) ? {2'b00, tx_word[7], 1'b0}
                 : (eff_w == W_DUAL) ? {2'b00, tx_word[7:6]}
                 : tx_word[7:4];
      end else begin
        nxt_tx_sh = tx_sh_ff << step;
        nxt_dout = (eff_w == W_SINGLE) ? {2'b00, tx_sh_ff[7], 1'b0}
                 : (eff_w == W_DUAL) ? {2'b00, tx_sh_ff[7:6]}
                 : tx_sh_ff[7:4];
      end
    end else if (!drive_i) begin
      nxt_drv = 4'h0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_ff <= 1'b0;
      cnt_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      dout_ff <= 4'h0;
      drv_ff <= 4'h0;
    end else begin
      sck_prev_ff <= s2_ff[PIN_SCK];
      cnt_ff <= nxt_cnt;
      rx_sh_ff <= nxt_rx_sh;
      tx_sh_ff <= nxt_tx_sh;
      dout_ff <= nxt_dout;
      drv_ff <= nxt_drv;
    end
  end

  // Enables drop at once on deselect or pause
  assign {data_line_3_oe_o, data_line_2_oe_o,
          data_line_1_oe_o, data_line_0_oe_o} =
         drv_ff & {LANES{active}};
  assign {data_line_3_o, data_line_2_o,
          data_line_1_o, data_line_0_o} = dout_ff;

  // ****************************************
  // Receive hand-off and two-entry buffer
  // ****************************************
  // The link cannot be stalled, so a byte waits in a holding
  // slot; a byte landing on a full slot is counted as overrun
  logic pend_v_ff;
  logic nxt_pend_v;
  logic [7:0] pend_ff;
  logic [7:0] nxt_pend;
  logic push;
  logic pop;
  logic [7:0] mem_ff [FIFO_DEPTH];
  logic [7:0] nxt_mem [FIFO_DEPTH];
  logic wp_ff;
  logic rp_ff;
  logic [1:0] cnt_q_ff;
  logic nxt_wp;
  logic nxt_rp;
  logic [1:0] nxt_cnt_q;
  logic ovr_ff;
  logic nxt_ovr;

  assign push = pend_v_ff && (cnt_q_ff != 2'(FIFO_DEPTH));
  assign pop = rx_valid_o && rx_ready_i;
  assign rx_valid_o = (cnt_q_ff != 2'h0);
  assign rx_data_o = mem_ff[rp_ff];
  assign overrun_o = ovr_ff;

  // Holding slot, buffer pointers and overrun flag
  always_comb begin
    nxt_pend_v = pend_v_ff & ~push;
    nxt_pend = pend_ff;
    if (byte_done) begin
      nxt_pend_v = 1'b1;
      nxt_pend = nxt_rx_sh;
    end
    // A new overrun beats a clear in the same cycle
    nxt_ovr = (ovr_ff & ~overrun_clr_i)
            | (byte_done & pend_v_ff & ~push);
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    if (push) begin
      nxt_mem[wp_ff] = pend_ff;
      nxt_wp = ~wp_ff;
    end
    if (pop) begin
      nxt_rp = ~rp_ff;
    end
    nxt_cnt_q = cnt_q_ff + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_v_ff <= 1'b0;
      pend_ff <= 8'h00;
      ovr_ff <= 1'b0;
      mem_ff <= '{default: 8'h00};
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      cnt_q_ff <= 2'h0;
    end else begin
      pend_v_ff <= nxt_pend_v;
      pend_ff <= nxt_pend;
      ovr_ff <= nxt_ovr;
      mem_ff <= nxt_mem;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_q_ff <= nxt_cnt_q;
    end
  end

  // ****************************************
  // Protected status bits
  // ****************************************
  logic [PROT_W-1:0] prot_ff;
  logic [PROT_W-1:0] nxt_prot;
  logic locked;

  assign quad_en = prot_ff[QUAD_POS];
  // Quad enable turns the protect pin into a plain lane
  assign locked = prot_ff[WDIS_POS] & ~wp_s & ~quad_en;

  // A locked write leaves all six bits untouched
  always_comb begin
    nxt_prot = prot_ff;
    if (sr_wr_i && !locked) begin
      nxt_prot = sr_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prot_ff <= PROT_RST;
    end else begin
      prot_ff <= nxt_prot;
    end
  end
  assign sr_bits_o = prot_ff;

  // ****************************************
  // Assertions
  // ****************************************
  a_standby_release: assert property (@(posedge clk_i) disable iff (!rst_n)
    standby_o |=> drv_ff == 4'h0)
    else $error("Pins driven while deselected");
  a_arm_first: assert property (@(posedge clk_i) disable iff (!rst_n)
    !armed_ff |=> link_ff == LS_IDLE)
    else $error("Link opened before select went high");
  a_select_open: assert property (@(posedge clk_i) disable iff (!rst_n)
    (link_ff == LS_IDLE && armed_ff && !cs_s) |=> active)
    else $error("Select low did not open link");
  a_ignore_desel: assert property (@(posedge clk_i) disable iff (!rst_n)
    cs_s |=> $stable(rx_sh_ff) && !byte_done)
    else $error("Data taken while deselected");
  a_rise_sample: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rx_go && eff_w == W_SINGLE)
      |=> rx_sh_ff == {$past(rx_sh_ff[6:0]), $past(s2_ff[0])})
    else $error("Single lane bit not sampled on rise");
  a_fall_drive: assert property (@(posedge clk_i) disable iff (!rst_n)
    !tx_go |=> $stable(dout_ff))
    else $error("Output changed off a falling edge");
  a_pause_release: assert property (@(posedge clk_i) disable iff (!rst_n)
    (active && !cs_s && !hold_s && !quad_en) |=> !data_line_1_oe_o)
    else $error("Output pin driven while paused");
  a_pause_freeze: assert property (@(posedge clk_i) disable iff (!rst_n)
    paused_o |=> $stable(cnt_ff) && $stable(rx_sh_ff))
    else $error("Sequence moved while paused");
  a_quad_no_pause: assert property (@(posedge clk_i) disable iff (!rst_n)
    quad_en |=> link_ff != LS_PAUSED)
    else $error("Pause honoured with quad enabled");
  a_quad_lanes: assert property (@(posedge clk_i) disable iff (!rst_n)
    (data_line_2_oe_o || data_line_3_oe_o) |-> quad_en)
    else $error("Upper lanes driven without quad enable");
  a_prot_lock: assert property (@(posedge clk_i) disable iff (!rst_n)
    (sr_wr_i && prot_ff[WDIS_POS] && !wp_s && !quad_en) |=> $stable(prot_ff))
    else $error("Locked status bits were written");
  a_prot_open: assert property (@(posedge clk_i) disable iff (!rst_n)
    (sr_wr_i && !prot_ff[WDIS_POS]) |=> prot_ff == $past(sr_wdata_i))
    else $error("Unlocked status write was lost");

endmodule

// *** test/spi_master_model.sv ***
`timescale 1ns/1ps
// Link master: select, clock and lanes at a 125 ns link period
module spi_master_model (
  // Pins toward the device
  output logic sel_n_o,
  output logic sck_o,
  output logic [3:0] lane_o,
  // Resolved lane levels
  input wire logic [3:0] lane_i
);
  logic idle_hi; // Clock level between frames

  // Select starts low, so no falling edge has been seen yet
  initial begin
    sel_n_o = 1'h0;
    sck_o = 1'h0;
    lane_o = 4'hF;
    idle_hi = 1'h0;
  end

  // Protect or pause level, set by the bench
  task automatic set_pin(input int k, input logic v);
    lane_o[k] = v;
  endtask

  // Frame start: select high, then low, with the clock parked
  task automatic open(input logic m3);
    idle_hi = m3;
    sel_n_o = 1'h1;
    sck_o = m3;
    #62.5;
    sel_n_o = 1'h0;
    #62.5;
  endtask

  // Select goes first, so the clock's return to idle is ignored
  task automatic close();
    sel_n_o = 1'h1;
    #62.5;
    sck_o = idle_hi;
    lane_o[3:2] = 2'h3;
    #62.5;
  endtask

  // Sends n chunks of w lanes, top bits first, set up before the rise
  task automatic put(input logic [7:0] b, input int w, input int n);
    for (int j = 0; j < n; j++) begin
      sck_o = 1'h0;
      for (int k = 0; k < w; k++) lane_o[k] = b[8-w+k];
      b = b << w;
      #62.5;
      sck_o = 1'h1;
      #62.5;
    end
  endtask

  // Reads n chunks at the rise; released lanes toggle, so stale levels
  // can never pass for fresh data
  task automatic get(output logic [7:0] b, input int w, input int n);
    logic [3:0] rel;
    rel = (w == 1) ? 4'h2 : 4'((1 << w) - 1);
    b = 8'h00;
    if (sck_o == 1'h0) begin
      sck_o = 1'h1;
      #62.5;
    end
    for (int j = 0; j < n; j++) begin
      sck_o = 1'h0;
      lane_o = lane_o ^ rel;
      #62.5;
      b = (w == 1) ? {b[6:0], lane_i[1]} : (b << w) | 8'(lane_i & rel);
      sck_o = 1'h1;
      #62.5;
    end
  endtask
endmodule

// *** test/serial_flash_pin_interface_test.sv ***
`timescale 1ns/1ps
module serial_flash_pin_interface_test;
  import flash_pin_pkg::*;
  // ****************************************
  // Signals and tables
  // ****************************************
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic sel_n, sck, drive_i, rx_ready_i, tx_valid_i, sr_wr_i, clr;
  logic rx_valid_o, tx_ready_o, standby_o, paused_o, overrun_o;
  logic [3:0] m_lane, dout, oe, pin, msk;
  logic [7:0] rx_data_o, tx_data_i, got, g2;
  logic [5:0] sr_wdata_i, sr_bits_o;
  width_t width_i;
  int miscompares = 0;
  int checks_done = 0;
  int tx_takes = 0; // Bytes taken for sending
  typedef struct {width_t w; logic quad; logic drv; logic m3; int n;
    logic [7:0] d;} row_t;
  row_t rows [7];
  row_t r;
  logic [12:0] prot [6]; // Protect pin, written bits, expected bits

  always #5 clk_i = ~clk_i;
  // Device wins a lane only where it drives
  assign pin = (oe & dout) | (~oe & m_lane);
  always @(posedge clk_i) if (tx_valid_i && tx_ready_o) tx_takes++;

  spi_master_model i_master (.sel_n_o(sel_n), .sck_o(sck),
    .lane_o(m_lane), .lane_i(pin));
  serial_flash_pin_interface i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n), .sck_i(sck),
    .data_line_0_i(pin[0]), .data_line_0_o(dout[0]),
    .data_line_0_oe_o(oe[0]), .data_line_1_i(pin[1]),
    .data_line_1_o(dout[1]), .data_line_1_oe_o(oe[1]),
    .data_line_2_i(pin[2]), .data_line_2_o(dout[2]),
    .data_line_2_oe_o(oe[2]), .data_line_3_i(pin[3]),
    .data_line_3_o(dout[3]), .data_line_3_oe_o(oe[3]),
    .width_i(width_i), .drive_i(drive_i), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .tx_data_i(tx_data_i), .sr_wr_i(sr_wr_i), .sr_wdata_i(sr_wdata_i),
    .sr_bits_o(sr_bits_o), .standby_o(standby_o), .paused_o(paused_o),
    .overrun_o(overrun_o), .overrun_clr_i(clr));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic chk(input string what, input logic [8:0] exp,
    input logic [8:0] seen);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits a bounded time for a byte, checks it, pops exactly one
  task automatic pop(input logic [7:0] exp);
    int t;
    t = 0;
    @(negedge clk_i);
    while (rx_valid_o !== 1'h1 && t < 200) begin
      @(negedge clk_i);
      t++;
    end
    chk("rx byte", {1'h1, exp}, {rx_valid_o, rx_data_o});
    rx_ready_i = 1'h1;
    @(negedge clk_i);
    rx_ready_i = 1'h0;
  endtask

  task automatic sr_write(input logic [5:0] v);
    @(negedge clk_i);
    sr_wr_i = 1'h1;
    sr_wdata_i = v;
    @(negedge clk_i);
    sr_wr_i = 1'h0;
    @(negedge clk_i);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs well under 200 us
  initial begin
    #200_000;
    miscompares++;
    stop_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {drive_i, rx_ready_i, tx_valid_i, sr_wr_i, clr} = 5'h00;
    width_i = W_SINGLE;
    tx_data_i = 8'h00;
    sr_wdata_i = 6'h00;
    rows = '{'{W_SINGLE, 1'h0, 1'h0, 1'h0, 1, 8'hA5},
      '{W_SINGLE, 1'h0, 1'h1, 1'h1, 1, 8'h3C},
      '{W_DUAL, 1'h0, 1'h0, 1'h1, 2, 8'h96},
      '{W_DUAL, 1'h0, 1'h1, 1'h0, 2, 8'hC3},
      '{W_QUAD, 1'h0, 1'h0, 1'h0, 1, 8'h69},
      '{W_QUAD, 1'h1, 1'h0, 1'h1, 4, 8'h5A},
      '{W_QUAD, 1'h1, 1'h1, 1'h0, 4, 8'h81}};
    prot = '{13'h0820, 13'h03E0, 13'h1BEF, 13'h1C30, 13'h0EBA, 13'h0000};
    wt(8);
    rst_n_i = 1'h1;
    wt(4);
    chk("reset", 9'h040, {2'h0, standby_o, oe, rx_valid_o, paused_o});
    chk("status reset", 9'h000, {3'h0, sr_bits_o});
    // Select low since power-up: no falling edge yet
    i_master.put(8'hE7, 1, 8);
    wt(6);
    chk("unarmed", 9'h100, {standby_o, rx_valid_o, 7'h00});
    i_master.close();
    i_master.put(8'h18, 1, 8);
    wt(6);
    chk("deselected", 9'h100, {standby_o, rx_valid_o, 7'h00});
    // A half byte cut by deselect must not shift the next byte
    i_master.open(1'h0);
    i_master.put(8'hFF, 1, 4);
    i_master.close();
    i_master.open(1'h0);
    chk("selected", 9'h000, {standby_o, 8'h00});
    i_master.put(8'h5C, 1, 8);
    pop(8'h5C);
    i_master.close();
    foreach (rows[i]) begin
      r = rows[i];
      sr_write({1'h0, r.quad, 4'h0});
      width_i = r.w;
      drive_i = r.drv;
      tx_data_i = r.d;
      tx_valid_i = r.drv;
      tx_takes = 0;
      i_master.open(r.m3);
      if (r.drv) begin
        i_master.get(got, r.n, 8 / r.n);
        msk = (r.n == 1) ? MASK_1 : (r.n == 2) ? MASK_2 : MASK_4;
        chk("tx byte", {1'h0, r.d}, {1'h0, got});
        chk("tx takes", 9'h001, 9'(tx_takes));
        chk("drive mask", {5'h00, msk}, {5'h00, oe});
      end else begin
        i_master.put(r.d, r.n, 8 / r.n);
        pop(r.d);
      end
      i_master.close();
      @(negedge clk_i);
      tx_valid_i = 1'h0;
      drive_i = 1'h0;
      chk("released", 9'h010, {4'h0, standby_o, oe});
    end
    // Protect pin against the write-disable and quad bits
    foreach (prot[i]) begin
      i_master.set_pin(2, prot[i][12]);
      wt(4);
      sr_write(prot[i][11:6]);
      chk("status", {3'h0, prot[i][5:0]}, {3'h0, sr_bits_o});
    end
    // Pause in mid-byte while sending; stray clocks must not count
    width_i = W_SINGLE;
    drive_i = 1'h1;
    tx_data_i = 8'hB4;
    tx_valid_i = 1'h1;
    i_master.open(1'h0);
    i_master.get(got, 1, 4);
    i_master.set_pin(3, 1'h0);
    wt(6);
    chk("paused", 9'h100, {paused_o, oe[1], 7'h00});
    i_master.put(8'h00, 1, 8);
    i_master.set_pin(3, 1'h1);
    #100;
    i_master.get(g2, 1, 4);
    chk("resumed", {1'h0, 8'hB4}, {1'h0, got[3:0], g2[3:0]});
    i_master.close();
    @(negedge clk_i);
    tx_valid_i = 1'h0;
    drive_i = 1'h0;
    // Quad mode turns the pause pin into a plain lane
    sr_write(6'h10);
    i_master.open(1'h0);
    i_master.set_pin(3, 1'h0);
    wt(6);
    chk("no pause", 9'h000, {paused_o, 8'h00});
    i_master.close();
    sr_write(6'h00);
    // Stalled consumer: buffer plus holding slot keep three bytes
    i_master.open(1'h0);
    for (int i = 1; i < 4; i++) i_master.put(8'(i * 17), 1, 8);
    wt(8);
    chk("stalled", 9'h100, {rx_valid_o, overrun_o, 7'h00});
    i_master.put(8'h44, 1, 8);
    wt(8);
    chk("overrun", 9'h001, {8'h00, overrun_o});
    i_master.close();
    pop(8'h11);
    pop(8'h22);
    rx_ready_i = 1'h1;
    wt(4);
    rx_ready_i = 1'h0;
    clr = 1'h1;
    wt(1);
    clr = 1'h0;
    wt(1);
    chk("drained", 9'h000, {rx_valid_o, overrun_o, 7'h00});
    // Reset in mid-frame: link drops, status clears, arming restarts
    sr_write(6'h2F);
    i_master.open(1'h0);
    i_master.put(8'hF0, 1, 3);
    wt(1);
    rst_n_i = 1'h0;
    wt(2);
    rst_n_i = 1'h1;
    wt(4);
    chk("reset 2", 9'h100, {standby_o, oe[1], paused_o, sr_bits_o});
    // Select low since that reset: still no instruction taken
    i_master.put(8'hF0, 1, 8);
    wt(6);
    chk("rearm", 9'h100, {standby_o, rx_valid_o, 7'h00});
    i_master.close();
    stop_test();
  end
endmodule
